// file: core/tct_chan.sv
// one capture/compare channel: pin sampling, edge and match detection, output pin state
// assumes counter, tick and overflow are from logic on core_clk; pin_in is asynchronous
`timescale 1ns/1ps
`default_nettype none
module tct_chan (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // configuration
  input wire tct_pkg::tct_chan_ctl_t ctl,
  input wire logic enable,
  input wire logic cap_block,
  input wire logic cmp_block,
  // counter
  input wire logic tick,
  input wire logic wrap,
  input wire logic [15:0] cnt,
  input wire logic [15:0] cmp_val,
  // pin
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_oe,
  // events
  output logic event_pulse,
  output logic capture_pulse
);
  logic [2:0] sync_reg;
  logic out_reg;
  logic full_reg;
  logic capture_mode;
  logic compare_mode;
  logic rise;
  logic fall;
  logic match;
  logic edge_hit;

  // first stage only feeds the second
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      sync_reg <= 3'h0;
    else
      sync_reg <= {sync_reg[1:0], pin_in};
  end

  assign capture_mode = (ctl.edge_level != tct_pkg::EL_OFF) && !ctl.buffered_select &&
                        !ctl.mode_select_low;
  assign compare_mode = (ctl.edge_level != tct_pkg::EL_OFF) &&
                        (ctl.buffered_select || ctl.mode_select_low);
  assign rise = sync_reg[1] && !sync_reg[2];
  assign fall = !sync_reg[1] && sync_reg[2];
  assign edge_hit = (ctl.edge_level[0] && rise) || (ctl.edge_level[1] && fall);
  assign match = enable && compare_mode && tick && !cmp_block && (cnt == cmp_val);
  assign capture_pulse = enable && capture_mode && edge_hit && !cap_block;
  assign event_pulse = capture_pulse || match;
  assign pin_out = out_reg;
  assign pin_oe = enable && compare_mode;

  // full duty is sampled only at the wrap so it starts with a new period
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      full_reg <= 1'b0;
    else if (wrap)
      full_reg <= ctl.full_duty_force && ctl.toggle_on_wrap &&
                  (ctl.edge_level == tct_pkg::EL_CLEAR);
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      out_reg <= 1'b1;
    else if (ctl.edge_level == tct_pkg::EL_OFF)
      out_reg <= !ctl.mode_select_low;
    else if (compare_mode && wrap && ctl.toggle_on_wrap)
      out_reg <= ctl.full_duty_force ? 1'b1 : !out_reg;
    else if (match)
    begin
      case (ctl.edge_level)
        tct_pkg::EL_TOGGLE: out_reg <= !out_reg;
        tct_pkg::EL_CLEAR: out_reg <= full_reg;
        tct_pkg::EL_SET: out_reg <= 1'b1;
        default: out_reg <= out_reg;
      endcase
    end
  end

  chk_wrap_wins: assert property (@(posedge core_clk) disable iff (!nrst)
    compare_mode && wrap && match && ctl.toggle_on_wrap && !ctl.full_duty_force &&
    ctl.edge_level != tct_pkg::EL_OFF |=> out_reg != $past(out_reg))
    else $error("overflow toggle lost to compare");
endmodule
`default_nettype wire

// file: core/tct_pkg.sv
// package for the two-channel timer: register indices, field positions, reset values, carriers
// assumes byte-wide registers placed one per aligned 32-bit APB word
//
// Contract
// - overflow flag sets when counter reaches modulo
// - overflow flag clears by read-then-write-zero only
// - overflow request equals flag and enable
// - halt bit freezes counter; reset sets halt
// - halt suppresses input captures
// - counter-clear zeroes counter and prescaler, self-clears
// - halt plus clear leaves counter at zero
// - prescale codes divide by one to sixty-four
// - high-byte read holds low byte until read
// - reset or clear zeroes both counter bytes
// - counter restarts at zero after modulo match
// - modulo high write blocks overflow until low
// - reset loads all ones into modulo
// - channel flag sets on capture edge or match
// - channel flag clears by read-then-write-zero only
// - channel request equals flag and enable
// - buffered select exists only in channel zero
// - buffered mode disables channel one and pin
// - mode and edge bits pick capture or compare
// - toggle on overflow, overflow beats compare
// - full-duty bit forces high from next period
// - buffered: last written value register takes control
package tct_pkg;
  // register word indices; byte address is four times the index
  localparam logic [5:0] IDX_STATUS = 6'h20;
  localparam logic [5:0] IDX_CNT_HI = 6'h21;
  localparam logic [5:0] IDX_CNT_LO = 6'h22;
  localparam logic [5:0] IDX_MOD_HI = 6'h23;
  localparam logic [5:0] IDX_MOD_LO = 6'h24;
  localparam logic [5:0] IDX_CH0_SC = 6'h25;
  localparam logic [5:0] IDX_CH0_HI = 6'h26;
  localparam logic [5:0] IDX_CH0_LO = 6'h27;
  localparam logic [5:0] IDX_CH1_SC = 6'h28;
  localparam logic [5:0] IDX_CH1_HI = 6'h29;
  localparam logic [5:0] IDX_CH1_LO = 6'h2A;
  // status/control field positions
  localparam int ST_FLAG = 7;
  localparam int ST_IRQ_EN = 6;
  localparam int ST_HALT = 5;
  localparam int ST_CLEAR = 4;
  localparam int ST_PS_LSB = 0;
  // channel status/control flag position; the rest maps onto tct_chan_ctl_t
  localparam int CH_FLAG = 7;
  // reset values and the unused prescale code
  localparam logic [2:0] PS_RESET = 3'h0;
  localparam logic [2:0] PS_UNUSED = 3'h7;
  localparam logic [15:0] MOD_RESET = 16'hFFFF;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  // edge/level codes
  localparam logic [1:0] EL_OFF = 2'h0;
  localparam logic [1:0] EL_TOGGLE = 2'h1;
  localparam logic [1:0] EL_CLEAR = 2'h2;
  localparam logic [1:0] EL_SET = 2'h3;

  typedef struct packed {
    logic irq_en;
    logic buffered_select;
    logic mode_select_low;
    logic [1:0] edge_level;
    logic toggle_on_wrap;
    logic full_duty_force;
  } tct_chan_ctl_t;

  localparam tct_chan_ctl_t CTL_RESET = 7'h00;
endpackage

// file: core/tct_prescale.sv
// prescaler: divides the bus clock by 1..64 into a one-cycle tick
// assumes run and clear come from logic on core_clk
`timescale 1ns/1ps
`default_nettype none
module tct_prescale (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // control
  input wire logic run,
  input wire logic clear,
  input wire logic [2:0] sel,
  // tick out
  output logic tick
);
  logic [5:0] div_reg;

  function automatic logic [5:0] sel_mask(input logic [2:0] s);
    sel_mask = 6'(({6'h00, 1'b1} << s) - 7'h01);
  endfunction

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      div_reg <= 6'h00;
    else if (clear)
      div_reg <= 6'h00;
    else if (run)
      div_reg <= div_reg + 6'h01;
  end

  // the last divider state of each period gives the tick
  assign tick = run && !clear && (sel != tct_pkg::PS_UNUSED) &&
                ((div_reg & sel_mask(sel)) == sel_mask(sel));

  chk_unused_code: assert property (@(posedge core_clk) disable iff (!nrst)
    sel == tct_pkg::PS_UNUSED |-> !tick) else $error("tick with unused prescale code");
  chk_div_two: assert property (@(posedge core_clk) disable iff (!nrst)
    run && !clear && sel == 3'h1 && tick ##1 run && !clear && sel == 3'h1 |-> !tick)
    else $error("divide by two ticked twice in a row");
endmodule
`default_nettype wire

// file: core/tct_regs.sv
// two-channel 16-bit timer with APB register access
// assumes one APB master on core_clk; brk_state comes from logic on core_clk
`timescale 1ns/1ps
`default_nettype none
module tct_regs (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // debug
  input wire logic brk_state,
  // channel pins
  input wire logic ch0_pin_in,
  output logic ch0_pin_out,
  output logic ch0_pin_oe,
  input wire logic ch1_pin_in,
  output logic ch1_pin_out,
  output logic ch1_pin_oe,
  // interrupt requests
  output logic ovf_irq,
  output logic ch0_irq,
  output logic ch1_irq
);
  logic [31:0] prdata_reg;
  logic err_reg;
  logic [15:0] cnt_reg;
  logic [15:0] mod_reg;
  logic [15:0] val0_reg;
  logic [15:0] val1_reg;
  logic [7:0] hold_reg;
  logic [7:0] snap_lo_reg;
  logic hold_valid_reg;
  logic mod_pend_reg;
  logic val0_pend_reg;
  logic val1_pend_reg;
  logic tof_reg;
  logic tof_arm_reg;
  logic overflow_irq_enable_reg;
  logic halt_reg;
  logic [2:0] ps_reg;
  logic [1:0] cf_reg;
  logic [1:0] cf_arm_reg;
  logic last_wr1_reg;
  logic act1_reg;
  tct_pkg::tct_chan_ctl_t ctl0_reg;
  tct_pkg::tct_chan_ctl_t ctl1_reg;
  tct_pkg::tct_chan_ctl_t ctl1_eff;
  logic [5:0] idx;
  logic mapped;
  logic acc;
  logic wr;
  logic rd;
  logic [7:0] wb;
  logic clear_wr;
  logic tick;
  logic adv;
  logic wrap;
  logic tof_set;
  logic [1:0] ev;
  logic cap0;
  logic cap1;
  logic buffered;
  logic [15:0] cmp0;

  function automatic logic [7:0] chan_byte(input logic flag, input tct_pkg::tct_chan_ctl_t c);
    chan_byte = {flag, c};
  endfunction

  function automatic logic hit(input logic [5:0] a, input logic [5:0] b);
    hit = (a == b);
  endfunction

  // apb decode; no wait states, read data is loaded into a flop in the setup phase
  assign idx = paddr[7:2];
  assign mapped = (paddr[1:0] == 2'h0) && (idx >= tct_pkg::IDX_STATUS) && (idx <= tct_pkg::IDX_CH1_LO);
  assign acc = psel && penable;
  assign wr = acc && pwrite && mapped;
  assign rd = acc && !pwrite && mapped;
  assign wb = pwdata[7:0];
  assign pready = penable;
  assign pslverr = penable && err_reg;
  assign prdata = prdata_reg;
  assign buffered = ctl0_reg.buffered_select;
  assign clear_wr = wr && hit(idx, tct_pkg::IDX_STATUS) && wb[tct_pkg::ST_CLEAR];

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      prdata_reg <= 32'h0000_0000;
      err_reg <= 1'b0;
      snap_lo_reg <= 8'h00;
    end
    else if (psel && !penable)
    begin
      err_reg <= !((paddr[1:0] == 2'h0) && (idx >= tct_pkg::IDX_STATUS) &&
                   (idx <= tct_pkg::IDX_CH1_LO));
      snap_lo_reg <= cnt_reg[7:0];
      prdata_reg <= 32'h0000_0000;
      case (idx)
        tct_pkg::IDX_STATUS: prdata_reg[7:0] <= {tof_reg, overflow_irq_enable_reg, halt_reg, 2'h0, ps_reg};
        tct_pkg::IDX_CNT_HI: prdata_reg[7:0] <= cnt_reg[15:8];
        tct_pkg::IDX_CNT_LO: prdata_reg[7:0] <= hold_valid_reg ? hold_reg : cnt_reg[7:0];
        tct_pkg::IDX_MOD_HI: prdata_reg[7:0] <= mod_reg[15:8];
        tct_pkg::IDX_MOD_LO: prdata_reg[7:0] <= mod_reg[7:0];
        tct_pkg::IDX_CH0_SC: prdata_reg[7:0] <= chan_byte(cf_reg[0], ctl0_reg);
        tct_pkg::IDX_CH0_HI: prdata_reg[7:0] <= val0_reg[15:8];
        tct_pkg::IDX_CH0_LO: prdata_reg[7:0] <= val0_reg[7:0];
        tct_pkg::IDX_CH1_SC: prdata_reg[7:0] <= buffered ? 8'h00 : chan_byte(cf_reg[1], ctl1_reg);
        tct_pkg::IDX_CH1_HI: prdata_reg[7:0] <= val1_reg[15:8];
        tct_pkg::IDX_CH1_LO: prdata_reg[7:0] <= val1_reg[7:0];
        default: prdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  // status/control bits; the clear bit is never stored
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      overflow_irq_enable_reg <= 1'b0;
      halt_reg <= 1'b1;
      ps_reg <= tct_pkg::PS_RESET;
    end
    else if (wr && hit(idx, tct_pkg::IDX_STATUS))
    begin
      overflow_irq_enable_reg <= wb[tct_pkg::ST_IRQ_EN];
      halt_reg <= wb[tct_pkg::ST_HALT];
      ps_reg <= wb[tct_pkg::ST_PS_LSB +: 3];
    end
  end

  tct_prescale u_prescale (
    .core_clk(core_clk),
    .nrst(nrst),
    .run(!halt_reg && !brk_state),
    .clear(clear_wr),
    .sel(ps_reg),
    .tick(tick)
  );

  assign adv = tick && !halt_reg && !brk_state;
  assign wrap = adv && (cnt_reg == mod_reg);
  assign tof_set = wrap && !mod_pend_reg;

  // counter bytes take no writes
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      cnt_reg <= tct_pkg::CNT_RESET;
    else if (clear_wr)
      cnt_reg <= tct_pkg::CNT_RESET;
    else if (wrap)
      cnt_reg <= tct_pkg::CNT_RESET;
    else if (adv)
      cnt_reg <= cnt_reg + 16'h0001;
  end

  // low byte held from the high-byte read until the low byte is read
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      hold_reg <= 8'h00;
      hold_valid_reg <= 1'b0;
    end
    else if (rd && hit(idx, tct_pkg::IDX_CNT_LO))
      hold_valid_reg <= 1'b0;
    else if (rd && hit(idx, tct_pkg::IDX_CNT_HI) && !hold_valid_reg)
    begin
      hold_reg <= snap_lo_reg;
      hold_valid_reg <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      mod_reg <= tct_pkg::MOD_RESET;
      mod_pend_reg <= 1'b0;
    end
    else if (wr && hit(idx, tct_pkg::IDX_MOD_HI))
    begin
      mod_reg[15:8] <= wb;
      mod_pend_reg <= 1'b1;
    end
    else if (wr && hit(idx, tct_pkg::IDX_MOD_LO))
    begin
      mod_reg[7:0] <= wb;
      mod_pend_reg <= 1'b0;
    end
  end

  // overflow flag; a new overflow disarms the pending clear and the set wins
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      tof_reg <= 1'b0;
      tof_arm_reg <= 1'b0;
    end
    else if (tof_set)
    begin
      tof_reg <= 1'b1;
      tof_arm_reg <= 1'b0;
    end
    else if (wr && hit(idx, tct_pkg::IDX_STATUS) && !wb[tct_pkg::ST_FLAG] && tof_arm_reg)
    begin
      tof_reg <= 1'b0;
      tof_arm_reg <= 1'b0;
    end
    else if (rd && hit(idx, tct_pkg::IDX_STATUS) && tof_reg)
      tof_arm_reg <= 1'b1;
  end

  assign ovf_irq = tof_reg && overflow_irq_enable_reg;

  // channel controls; buffered select only lives in channel zero
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ctl0_reg <= tct_pkg::CTL_RESET;
      ctl1_reg <= tct_pkg::CTL_RESET;
    end
    else if (wr && hit(idx, tct_pkg::IDX_CH0_SC))
      ctl0_reg <= wb[6:0];
    else if (wr && hit(idx, tct_pkg::IDX_CH1_SC) && !buffered)
    begin
      ctl1_reg <= wb[6:0];
      ctl1_reg.buffered_select <= 1'b0;
    end
  end

  // channel flags, same two-step clear as the overflow flag
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cf_reg <= 2'h0;
      cf_arm_reg <= 2'h0;
    end
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        if (ev[i])
        begin
          cf_reg[i] <= 1'b1;
          cf_arm_reg[i] <= 1'b0;
        end
        else if (wr && hit(idx, i == 0 ? tct_pkg::IDX_CH0_SC : tct_pkg::IDX_CH1_SC) &&
                 !wb[tct_pkg::CH_FLAG] && cf_arm_reg[i])
        begin
          cf_reg[i] <= 1'b0;
          cf_arm_reg[i] <= 1'b0;
        end
        else if (rd && hit(idx, i == 0 ? tct_pkg::IDX_CH0_SC : tct_pkg::IDX_CH1_SC) && cf_reg[i])
          cf_arm_reg[i] <= 1'b1;
      end
    end
  end

  assign ch0_irq = cf_reg[0] && ctl0_reg.irq_en;
  assign ch1_irq = cf_reg[1] && ctl1_reg.irq_en && !buffered;

  // value registers; high write holds off compares until the low write
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      val0_reg <= 16'h0000;
      val1_reg <= 16'h0000;
      val0_pend_reg <= 1'b0;
      val1_pend_reg <= 1'b0;
      last_wr1_reg <= 1'b0;
    end
    else
    begin
      if (cap0)
        val0_reg <= cnt_reg;
      else if (wr && hit(idx, tct_pkg::IDX_CH0_HI))
        {val0_reg[15:8], val0_pend_reg, last_wr1_reg} <= {wb, 2'b10};
      else if (wr && hit(idx, tct_pkg::IDX_CH0_LO))
        {val0_reg[7:0], val0_pend_reg, last_wr1_reg} <= {wb, 2'b00};
      if (cap1)
        val1_reg <= cnt_reg;
      else if (wr && hit(idx, tct_pkg::IDX_CH1_HI))
        {val1_reg[15:8], val1_pend_reg, last_wr1_reg} <= {wb, 2'b11};
      else if (wr && hit(idx, tct_pkg::IDX_CH1_LO))
        {val1_reg[7:0], val1_pend_reg, last_wr1_reg} <= {wb, 2'b01};
    end
  end

  // in buffered mode the active value register switches only at a wrap
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      act1_reg <= 1'b0;
    else if (!buffered)
      act1_reg <= 1'b0;
    else if (wrap)
      act1_reg <= last_wr1_reg;
  end

  assign cmp0 = (buffered && act1_reg) ? val1_reg : val0_reg;
  assign ctl1_eff = ctl1_reg;

  tct_chan u_ch0 (
    .core_clk(core_clk),
    .nrst(nrst),
    .ctl(ctl0_reg),
    .enable(1'b1),
    .cap_block(halt_reg || brk_state),
    .cmp_block(buffered && act1_reg ? val1_pend_reg : val0_pend_reg),
    .tick(adv),
    .wrap(wrap),
    .cnt(cnt_reg),
    .cmp_val(cmp0),
    .pin_in(ch0_pin_in),
    .pin_out(ch0_pin_out),
    .pin_oe(ch0_pin_oe),
    .event_pulse(ev[0]),
    .capture_pulse(cap0)
  );

  tct_chan u_ch1 (
    .core_clk(core_clk),
    .nrst(nrst),
    .ctl(ctl1_eff),
    .enable(!buffered),
    .cap_block(halt_reg || brk_state),
    .cmp_block(val1_pend_reg),
    .tick(adv),
    .wrap(wrap),
    .cnt(cnt_reg),
    .cmp_val(val1_reg),
    .pin_in(ch1_pin_in),
    .pin_out(ch1_pin_out),
    .pin_oe(ch1_pin_oe),
    .event_pulse(ev[1]),
    .capture_pulse(cap1)
  );

  chk_tof_on_match: assert property (@(posedge core_clk) disable iff (!nrst)
    adv && cnt_reg == mod_reg && !mod_pend_reg |=> tof_reg) else $error("overflow flag not set");
  chk_tof_one_ignored: assert property (@(posedge core_clk) disable iff (!nrst)
    tof_reg && !(wr && hit(idx, tct_pkg::IDX_STATUS) && !wb[tct_pkg::ST_FLAG]) |=> tof_reg)
    else $error("overflow flag cleared without a zero write");
  chk_ovf_request: assert property (@(posedge core_clk) disable iff (!nrst)
    $rose(tof_reg) && overflow_irq_enable_reg |-> ovf_irq) else $error("overflow request missing");
  chk_halt_freeze: assert property (@(posedge core_clk) disable iff (!nrst)
    halt_reg && !clear_wr |=> $stable(cnt_reg)) else $error("counter moved while halted");
  chk_clear_zero: assert property (@(posedge core_clk) disable iff (!nrst)
    clear_wr |=> cnt_reg == 16'h0000 && !prdata_reg[tct_pkg::ST_CLEAR]) else $error("clear did not zero counter");
  chk_wrap_zero: assert property (@(posedge core_clk) disable iff (!nrst)
    wrap && !clear_wr |=> cnt_reg == 16'h0000) else $error("counter did not restart");
  chk_mod_block: assert property (@(posedge core_clk) disable iff (!nrst)
    mod_pend_reg && !tof_reg |=> !tof_reg) else $error("overflow flag set during modulo write");
  chk_hold_stable: assert property (@(posedge core_clk) disable iff (!nrst)
    hold_valid_reg && !(rd && hit(idx, tct_pkg::IDX_CNT_LO)) |=> hold_valid_reg && $stable(hold_reg))
    else $error("held low byte changed");
  chk_cap_halt: assert property (@(posedge core_clk) disable iff (!nrst)
    halt_reg |-> !cap0 && !cap1) else $error("capture while halted");
  chk_ch1_off: assert property (@(posedge core_clk) disable iff (!nrst)
    buffered |-> !ch1_pin_oe && !ev[1]) else $error("channel one active in buffered mode");
  chk_ch_request: assert property (@(posedge core_clk) disable iff (!nrst)
    ev[0] && ctl0_reg.irq_en && !(wr && hit(idx, tct_pkg::IDX_CH0_SC)) |=> ch0_irq)
    else $error("channel zero request missing");

  cov_overflow: cover property (@(posedge core_clk) disable iff (!nrst) $rose(tof_reg));
  cov_buffer_switch: cover property (@(posedge core_clk) disable iff (!nrst) buffered && $changed(act1_reg));
  cov_halt_clear: cover property (@(posedge core_clk) disable iff (!nrst)
    clear_wr && wb[tct_pkg::ST_HALT]);
  cov_capture: cover property (@(posedge core_clk) disable iff (!nrst) cap0);
endmodule
`default_nettype wire

// file: tb/tct_regs_tb.sv
// self-checking testbench for the two-channel timer register block
// assumes tct_regs answers APB with no wait states; ports are driven directly, no far-side model
`timescale 1ns/1ps
`default_nettype none
module tct_regs_tb;
  localparam logic [7:0] ST = {tct_pkg::IDX_STATUS, 2'b00};
  localparam logic [7:0] CH = {tct_pkg::IDX_CNT_HI, 2'b00};
  localparam logic [7:0] CL = {tct_pkg::IDX_CNT_LO, 2'b00};
  localparam logic [7:0] MH = {tct_pkg::IDX_MOD_HI, 2'b00};
  localparam logic [7:0] ML = {tct_pkg::IDX_MOD_LO, 2'b00};
  localparam logic [7:0] S0 = {tct_pkg::IDX_CH0_SC, 2'b00};
  localparam logic [7:0] V0H = {tct_pkg::IDX_CH0_HI, 2'b00};
  localparam logic [7:0] V0L = {tct_pkg::IDX_CH0_LO, 2'b00};
  localparam logic [7:0] S1 = {tct_pkg::IDX_CH1_SC, 2'b00};
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, ch0_out, ch0_oe, ch1_out, ch1_oe, ovf_irq, ch0_irq, ch1_irq;
  logic ch1_pin = 1'b0;
  logic brk = 1'b0;
  logic [7:0] q;
  logic err;
  int failures = 0;
  int compares = 0;
  int cycles = 0;

  tct_regs u_dut (.core_clk(core_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .brk_state(brk), .ch0_pin_in(1'b0), .ch0_pin_out(ch0_out), .ch0_pin_oe(ch0_oe),
    .ch1_pin_in(ch1_pin), .ch1_pin_out(ch1_out), .ch1_pin_oe(ch1_oe),
    .ovf_irq(ovf_irq), .ch0_irq(ch0_irq), .ch1_irq(ch1_irq));

  always #50 core_clk = ~core_clk;

  // a hang costs a mismatch, then the normal closing report
  always @(posedge core_clk)
  begin
    cycles = cycles + 1;
    if (cycles == 20000)
    begin
      failures = failures + 1;
      conclude();
    end
  end

  task automatic conclude();
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic check8(input logic [7:0] g, input logic [7:0] e);
    compares = compares + 1;
    if (g !== e)
    begin
      failures = failures + 1;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic check_rng(input logic [7:0] g, input int lo, input int hi);
    compares = compares + 1;
    if ($isunknown(g) || int'(g) < lo || int'(g) > hi)
    begin
      failures = failures + 1;
      $display("Error at %0t: got %h expected %h..%h", $time, g, lo, hi);
    end
  endtask

  // one APB transfer; request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    q = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    check8(q, e);
  endtask

  task automatic t_reset();
    rd(ST, 8'h20);
    rd(CH, 8'h00);
    rd(CL, 8'h00);
    rd(MH, 8'hFF);
    rd(ML, 8'hFF);
    rd(S0, 8'h00);
    check8({5'h0, ovf_irq, ch0_irq, ch1_irq}, 8'h00);
    check8({4'h0, ch0_out, ch1_out, ch0_oe, ch1_oe}, 8'h0C);
    apb(1'b0, 8'h00, 8'h00);
    check8({7'h0, err}, 8'h01);
    wr(CH, 8'hFF);
    rd(CH, 8'h00);
    // unlatch the low byte so the next high-byte read takes a fresh one
    rd(CL, 8'h00);
    $display("test reset done");
  endtask

  task automatic t_prescale();
    for (int k = 0; k < 8; k++)
    begin
      wr(ST, 8'h30 | k[7:0]);
      wr(ST, k[7:0]);
      repeat (128) @(posedge core_clk);
      wr(ST, 8'h20 | k[7:0]);
      rd(ST, 8'h20 | k[7:0]);
      rd(CH, 8'h00);
      apb(1'b0, CL, 8'h00);
      check_rng(q, (k == 7) ? 0 : (128 >> k) - 1, (k == 7) ? 0 : (134 >> k) + 1);
    end
    $display("test prescale done");
  endtask

  task automatic t_latch();
    wr(ST, 8'h36);
    rd(CH, 8'h00);
    rd(CL, 8'h00);
    wr(ST, 8'h06);
    rd(CH, 8'h00);
    repeat (300) @(posedge core_clk);
    rd(CH, 8'h00);
    apb(1'b0, CL, 8'h00);
    check_rng(q, 0, 1);
    apb(1'b0, CL, 8'h00);
    check_rng(q, 3, 6);
    // break freezes the count; the low byte is unlatched before leaving it
    brk <= 1'b1;
    repeat (100) @(posedge core_clk);
    rd(CH, 8'h00);
    apb(1'b0, CL, 8'h00);
    check_rng(q, 3, 5);
    brk <= 1'b0;
    $display("test latch done");
  endtask

  task automatic t_modulo();
    wr(ST, 8'h30);
    wr(MH, 8'h00);
    wr(ST, 8'h40);
    repeat (300) @(posedge core_clk);
    rd(ST, 8'h40);
    check8({7'h0, ovf_irq}, 8'h00);
    wr(ST, 8'h70);
    wr(ML, 8'h05);
    wr(ST, 8'h40);
    repeat (20) @(posedge core_clk);
    check8({7'h0, ovf_irq}, 8'h01);
    wr(ST, 8'h60);
    rd(ST, 8'hE0);
    apb(1'b0, CL, 8'h00);
    check_rng(q, 0, 5);
    // a write of one keeps the flag; the next overflow disarms the clear
    wr(ST, 8'hC0);
    repeat (20) @(posedge core_clk);
    wr(ST, 8'h60);
    rd(ST, 8'hE0);
    wr(ST, 8'h60);
    rd(ST, 8'h60);
    check8({7'h0, ovf_irq}, 8'h00);
    $display("test modulo done");
  endtask

  task automatic t_channels();
    wr(V0H, 8'h00);
    wr(V0L, 8'h03);
    wr(S0, 8'h54);
    @(posedge core_clk);
    check8({7'h0, ch0_oe}, 8'h01);
    wr(ST, 8'h00);
    repeat (20) @(posedge core_clk);
    wr(ST, 8'h20);
    check8({7'h0, ch0_irq}, 8'h01);
    rd(S0, 8'hD4);
    wr(S0, 8'h54);
    rd(S0, 8'h54);
    check8({7'h0, ch0_irq}, 8'h00);
    // capture while halted must stay silent
    wr(S1, 8'h44);
    ch1_pin <= 1'b1;
    repeat (10) @(posedge core_clk);
    rd(S1, 8'h44);
    ch1_pin <= 1'b0;
    repeat (5) @(posedge core_clk);
    wr(ST, 8'h00);
    ch1_pin <= 1'b1;
    repeat (10) @(posedge core_clk);
    wr(ST, 8'h20);
    rd(S1, 8'hC4);
    check8({7'h0, ch1_irq}, 8'h01);
    wr(S1, 8'h24);
    rd(S1, 8'h04);
    wr(S1, 8'h54);
    @(posedge core_clk);
    check8({7'h0, ch1_oe}, 8'h01);
    // channel zero kept comparing during the capture run, and the unarmed write leaves its flag
    wr(S0, 8'h64);
    rd(S0, 8'hE4);
    check8({7'h0, ch1_oe}, 8'h00);
    rd(S1, 8'h00);
    $display("test channels done");
  endtask

  initial
  begin
    repeat (4) @(posedge core_clk);
    nrst <= 1'b1;
    t_reset();
    t_prescale();
    t_latch();
    t_modulo();
    t_channels();
    conclude();
  end
endmodule
`default_nettype wire
